//--- logic/pcsc_regs.svh
/*
 register indices, field positions, reset values and emergency encodings of the pump
 status, control and run-mode objects. assumes an object-dictionary access path that
 presents a 16-bit index, a write strobe and write data on the node clock.
*/
`ifndef PCSC_REGS_SVH
`define PCSC_REGS_SVH
`define PCSC_IDX_STATUS     16'h2A10
`define PCSC_IDX_CONTROL    16'h2A11
`define PCSC_IDX_RUN_MODE   16'h2A12
`define PCSC_CTRL_RESET_BIT 6
`define PCSC_CTRL_CAL_BIT   3
`define PCSC_CTRL_BATCH_BIT 1
`define PCSC_CTRL_WR_MASK   8'h5A
`define PCSC_MODE_WR_MASK   8'h03
`define PCSC_MODE_STOP      8'h00
`define PCSC_MODE_CONT      8'h01
`define PCSC_MODE_BATCH     8'h02
`define PCSC_RESET_CONTROL  8'h00
`define PCSC_RESET_MODE     8'h00
`define PCSC_EMCY_COB_BASE  11'h080
`define PCSC_CODE_PUMP      16'hFF01
`define PCSC_CODE_TEMP      16'h4201
`define PCSC_CODE_MODULE    16'h8101
`define PCSC_EREG_PUMP      8'h81
`define PCSC_EREG_TEMP      8'h09
`define PCSC_EREG_MODULE    8'h11
`define PCSC_COMPONENT      8'h01
`define PCSC_CLASS_WARN     8'h01
`define PCSC_CLASS_ERR      8'h02
`define PCSC_CLASS_HORN     8'h04
`define PCSC_CODE_COMM      16'h8100
`define PCSC_CODE_OVERRUN   16'h8110
`define PCSC_CODE_PASSIVE   16'h8120
`define PCSC_CODE_HEARTBEAT 16'h8130
`define PCSC_CODE_BUSOFF    16'h8140
`define PCSC_CODE_PDO_UNPROC 16'h8210
`define PCSC_CODE_PDO_LONG  16'h8220
`define PCSC_NUM_FAULTS     16
`define PCSC_NUM_STACK      7
`endif

//--- logic/pcsc_pkg.sv
/*
 types of the pump status and control block. assumes pcsc_regs.svh is on the include path.
*/
package pcsc_pkg;
   typedef enum logic [1:0] {
      PCSC_IDLE,
      PCSC_SEND
   } pcsc_state_t;

   typedef struct packed {
      pcsc_state_t state;
      logic [7:0]  control;
      logic [7:0]  run_mode;
      logic [15:0] fault_pend;
      logic [6:0]  stack_pend;
      logic [15:0] fault_prev;
      logic [15:0] rd_data;
      logic        emcy_valid;
      logic [10:0] emcy_id;
      logic [63:0] emcy_data;
   } pcsc_regs_t;
endpackage : pcsc_pkg

//--- logic/pcsc_core.sv
/*
 status word, control byte, run-mode byte and emergency frame encoder of a metering pump
 node. assumes the protocol stack presents object accesses as index plus strobes, accepts
 one emergency frame at a time through valid/ready, and pulses stack_event bits.
*/
`timescale 1ns/1ps
`include "pcsc_regs.svh"
module pcsc_core (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [6:0]  node_id,
   input  wire logic [15:0] obj_index,
   input  wire logic        obj_wr,
   input  wire logic        obj_rd,
   input  wire logic [7:0]  obj_wdata,
   output logic      [15:0] obj_rdata,
   input  wire logic [15:0] pump_cond,
   input  wire logic [15:0] fault_level,
   input  wire logic        horn_active,
   input  wire logic [6:0]  stack_event,
   output logic             errors_clear,
   output logic             batch_memory_zero,
   output logic      [7:0]  pump_control_byte,
   output logic      [7:0]  pump_run_mode,
   output logic             emcy_valid,
   input  wire logic        emcy_ready,
   output logic      [10:0] emcy_id,
   output logic      [63:0] emcy_data
);
   import pcsc_pkg::*;

   // ==========================================================
   // fault encoding tables
   // ==========================================================
   // fault index: 0 level w, 1 metering w, 2 diaphragm w, 3 stroke w, 4 overload w,
   // 5 temperature w, 6 level e, 7 overflow e, 8 <4mA, 9 >20mA, 10 stroke metering,
   // 11 rupture, 12 stroke adjusted, 13 system, 14 module comm, 15 module missing
   localparam logic [7:0] FAULT_TYPE [`PCSC_NUM_FAULTS] = '{
      8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h21, 8'h22,
      8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2A, 8'h2C, 8'h2D};
   localparam logic [15:0] STACK_CODE [`PCSC_NUM_STACK] = '{
      `PCSC_CODE_COMM, `PCSC_CODE_OVERRUN, `PCSC_CODE_PASSIVE, `PCSC_CODE_HEARTBEAT,
      `PCSC_CODE_BUSOFF, `PCSC_CODE_PDO_UNPROC, `PCSC_CODE_PDO_LONG};

   function automatic logic [63:0] fault_frame(input logic [3:0] idx, input logic horn);
      logic [15:0] code;
      logic [7:0]  ereg;
      logic [7:0]  cls;
      code = `PCSC_CODE_PUMP;
      ereg = `PCSC_EREG_PUMP;
      if (idx == 4'h5) begin
         code = `PCSC_CODE_TEMP;
         ereg = `PCSC_EREG_TEMP;
      end else if (idx >= 4'hE) begin
         code = `PCSC_CODE_MODULE;
         ereg = `PCSC_EREG_MODULE;
      end
      cls = (idx < 4'h6) ? `PCSC_CLASS_WARN : `PCSC_CLASS_ERR;
      if (horn) begin
         cls = cls | `PCSC_CLASS_HORN;
      end
      // byte 0 first on the wire: code low, code high, register, component, type, class, free
      fault_frame = {8'h00, 8'h00, cls, FAULT_TYPE[idx], `PCSC_COMPONENT, ereg, code[15:8], code[7:0]};
   endfunction : fault_frame

   pcsc_regs_t r;
   pcsc_regs_t next_r;
   logic       reset_hit;
   logic [15:0] status_word;
   logic [15:0] fault_rise;

   // ==========================================================
   // combinational next state
   // ==========================================================
   assign reset_hit  = obj_wr && (obj_index == `PCSC_IDX_CONTROL) && obj_wdata[`PCSC_CTRL_RESET_BIT];
   assign fault_rise = fault_level & ~r.fault_prev;
   // bit 13 unused; the rest mirror the pump's live conditions
   assign status_word = {pump_cond[15:14], 1'b0, pump_cond[12:0]};

   always_comb begin
      logic       found;
      found  = 1'b0;
      next_r = r;
      next_r.fault_prev = fault_level;
      // a new rise sets its pending bit even while software clears errors
      next_r.fault_pend = r.fault_pend | fault_rise;
      next_r.stack_pend = r.stack_pend | stack_event;
      if (obj_rd) begin
         unique case (obj_index)
            `PCSC_IDX_STATUS:   next_r.rd_data = status_word;
            `PCSC_IDX_CONTROL:  next_r.rd_data = {8'h00, r.control};
            `PCSC_IDX_RUN_MODE: next_r.rd_data = {8'h00, r.run_mode};
            default:            next_r.rd_data = 16'h0000;
         endcase
      end
      if (obj_wr && obj_index == `PCSC_IDX_CONTROL) begin
         // must-be-zero bits are not stored so the byte reads back clean
         next_r.control = obj_wdata & `PCSC_CTRL_WR_MASK;
      end
      if (obj_wr && obj_index == `PCSC_IDX_RUN_MODE) begin
         next_r.run_mode = obj_wdata & `PCSC_MODE_WR_MASK;
      end
      if (reset_hit) begin
         next_r.run_mode   = `PCSC_MODE_STOP;
         next_r.fault_pend = fault_rise;
         next_r.control[`PCSC_CTRL_RESET_BIT] = 1'b0;
      end
      unique case (r.state)
         PCSC_IDLE: begin
            for (int i = 0; i < `PCSC_NUM_FAULTS; i++) begin
               if (!found && next_r.fault_pend[i]) begin
                  found = 1'b1;
                  next_r.fault_pend[i] = 1'b0;
                  next_r.emcy_data = fault_frame(4'(i), horn_active);
               end
            end
            for (int j = 0; j < `PCSC_NUM_STACK; j++) begin
               if (!found && next_r.stack_pend[j]) begin
                  found = 1'b1;
                  next_r.stack_pend[j] = 1'b0;
                  // stack frames carry only code and a generic register byte
                  next_r.emcy_data = {40'h00_0000_0000, 8'h01, STACK_CODE[j][15:8], STACK_CODE[j][7:0]};
               end
            end
            if (found) begin
               next_r.emcy_id    = `PCSC_EMCY_COB_BASE + {4'h0, node_id};
               next_r.emcy_valid = 1'b1;
               next_r.state      = PCSC_SEND;
            end
         end
         PCSC_SEND: begin
            if (emcy_ready) begin
               next_r.emcy_valid = 1'b0;
               next_r.state      = PCSC_IDLE;
            end
         end
      endcase
   end

   // ==========================================================
   // state register
   // ==========================================================
   always_ff @(posedge mclk) begin
      if (rst) begin
         r          <= '0;
         r.state    <= PCSC_IDLE;
         r.control  <= `PCSC_RESET_CONTROL;
         r.run_mode <= `PCSC_RESET_MODE;
      end else begin
         r <= next_r;
      end
   end

   assign obj_rdata         = r.rd_data;
   assign pump_control_byte = r.control;
   assign pump_run_mode     = r.run_mode;
   assign errors_clear      = reset_hit;
   assign batch_memory_zero = reset_hit;
   assign emcy_valid        = r.emcy_valid;
   assign emcy_id           = r.emcy_id;
   assign emcy_data         = r.emcy_data;
endmodule : pcsc_core

//--- dv/pcsc_checker.sv
/* port checker of pcsc_core. assumes it is bound to every pcsc_core instance. */
`timescale 1ns/1ps
module pcsc_checker (
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic [6:0]  node_id,
   input wire logic [15:0] obj_index,
   input wire logic        obj_wr,
   input wire logic        obj_rd,
   input wire logic [7:0]  obj_wdata,
   input wire logic [15:0] obj_rdata,
   input wire logic [15:0] pump_cond,
   input wire logic [15:0] fault_level,
   input wire logic        errors_clear,
   input wire logic        batch_memory_zero,
   input wire logic [7:0]  pump_control_byte,
   input wire logic [7:0]  pump_run_mode,
   input wire logic        emcy_valid,
   input wire logic        emcy_ready,
   input wire logic [10:0] emcy_id,
   input wire logic [63:0] emcy_data
);
   // ====
   // properties
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence idle_s; !emcy_valid [*2]; endsequence
   sequence clr_s; obj_wr && obj_index == 16'h2A11 && obj_wdata[6]; endsequence
   id_a: assert property (emcy_valid |-> emcy_id == 11'h080 + {4'h0, node_id})
      else $error("frame id wrong");
   frame_hold_a: assert property (emcy_valid && !emcy_ready |=> emcy_valid && $stable(emcy_data))
      else $error("frame dropped before accept");
   status_ro_a: assert property (obj_rd && obj_index == 16'h2A10
      |=> obj_rdata == ($past(pump_cond) & 16'hDFFF))
      else $error("status read wrong");
   run_mode_a: assert property (obj_wr && obj_index == 16'h2A12
      |=> pump_run_mode == ($past(obj_wdata) & 8'h03))
      else $error("run mode write wrong");
   ctrl_bits_a: assert property (obj_wr && obj_index == 16'h2A11
      |=> (pump_control_byte & 8'hAF) == ($past(obj_wdata) & 8'h0A))
      else $error("control byte write wrong");
   reset_stop_a: assert property (clr_s |-> errors_clear && batch_memory_zero ##1 pump_run_mode == 8'h00)
      else $error("reset write did not stop");
   clear_cause_a: assert property (errors_clear || batch_memory_zero |-> clr_s)
      else $error("clear without reset write");
   // pump warnings carry class 01 and pump errors class 02, with 04 added while the horn is on, so bit0 and bit1 are opposites
   class_bits_a: assert property (emcy_valid && emcy_data[31:24] == 8'h01
      |-> emcy_data[41] == (emcy_data[39:32] > 8'h20) && emcy_data[40] == !emcy_data[41])
      else $error("class byte wrong");
   fault_emcy_a: assert property (idle_s ##0 $rose(fault_level[0]) |=> emcy_valid && emcy_data[39:32] == 8'h01)
      else $error("level warning frame missing");
endmodule : pcsc_checker
bind pcsc_core pcsc_checker u_pcsc_checker (.mclk, .rst, .node_id, .obj_index, .obj_wr, .obj_rd, .obj_wdata,
   .obj_rdata, .pump_cond, .fault_level, .errors_clear, .batch_memory_zero, .pump_control_byte, .pump_run_mode,
   .emcy_valid, .emcy_ready, .emcy_id, .emcy_data);

//--- dv/pcsc_master_model.sv
/* bus master taking emergency frames. assumes the bench sets how long each is held off. */
`timescale 1ns/1ps
module pcsc_master_model (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic [3:0] stall,
   input  wire logic       emcy_valid,
   output logic            emcy_ready
);
   logic [3:0] waited;
   // holding ready back proves the frame stands until taken
   assign emcy_ready = emcy_valid && waited >= stall;
   always_ff @(posedge mclk) waited <= (rst || !emcy_valid || emcy_ready) ? 4'h0 : waited + 4'h1;
endmodule : pcsc_master_model

//--- dv/tb.sv
/* bench of pcsc_core. assumes the checker is bound and the master model takes frames. */
`timescale 1ns/1ps
module tb;
   logic mclk = 0, rst = 1, obj_wr = 0, obj_rd = 0, horn_active = 0, errors_clear, batch_memory_zero;
   logic emcy_valid, emcy_ready;
   logic [6:0] node_id = 7'h05, stack_event = 7'h00;
   logic [15:0] obj_index = 16'h0000, pump_cond = 16'hA5A5, fault_level = 16'h0000, obj_rdata;
   logic [7:0] obj_wdata = 8'h00, pump_control_byte, pump_run_mode;
   logic [3:0] stall = 4'h0;
   logic [10:0] emcy_id;
   logic [63:0] emcy_data;
   int fails = 0, n_tests = 0;
   logic [7:0] ftype [16] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
                              8'h26, 8'h27, 8'h2A, 8'h2C, 8'h2D};
   logic [15:0] scode [7] = '{16'h8100, 16'h8110, 16'h8120, 16'h8130, 16'h8140, 16'h8210, 16'h8220};
   logic [7:0] wm [4] = '{8'h00, 8'h01, 8'h02, 8'hFE};
   initial forever #12.5 mclk = ~mclk;
   pcsc_core u_pcsc_core (.mclk, .rst, .node_id, .obj_index, .obj_wr, .obj_rd, .obj_wdata, .obj_rdata,
      .pump_cond, .fault_level, .horn_active, .stack_event, .errors_clear, .batch_memory_zero,
      .pump_control_byte, .pump_run_mode, .emcy_valid, .emcy_ready, .emcy_id, .emcy_data);
   pcsc_master_model u_pcsc_master_model (.mclk, .rst, .stall, .emcy_valid, .emcy_ready);
   // ====
   // tasks
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : report_and_stop
   task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      @(posedge mclk);
      obj_index <= idx;
      obj_wdata <= d;
      obj_wr <= 1'b1;
      @(posedge mclk);
      obj_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
      @(posedge mclk);
      obj_index <= idx;
      obj_rd <= 1'b1;
      @(posedge mclk);
      obj_rd <= 1'b0;
      #1 cmp("read", {48'h0, exp}, {48'h0, obj_rdata});
   endtask : rd
   // frame data is taken in the cycle that ends with the accepting edge
   // looks before the first edge too, so a frame raised on the calling edge is not missed
   task automatic frame(input logic [63:0] exp);
      int i;
      for (i = 0; i < 40; i++) begin
         #1;
         if (emcy_valid && emcy_ready) break;
         @(posedge mclk);
      end
      if (i == 40) begin
         fails++;
         report_and_stop();
      end else begin
         cmp("frame", exp, emcy_data);
         cmp("frame id", {53'h0, 11'h080 + {4'h0, node_id}}, {53'h0, emcy_id});
      end
      @(posedge mclk);
   endtask : frame
   function automatic logic [63:0] frm(input logic [15:0] c, input logic [7:0] r, p, t, k);
      return {16'h0000, k, t, p, r, c};
   endfunction : frm
   // ====
   // sequence
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      rd(16'h2A10, 16'h85A5);
      wr(16'h2A10, 8'hFF);
      rd(16'h2A10, 16'h85A5);
      rd(16'h2A13, 16'h0000);
      @(posedge mclk) pump_cond <= 16'h5A5A;
      rd(16'h2A10, 16'h5A5A);
      $display("status test done");
      for (int m = 0; m < 4; m++) begin
         wr(16'h2A12, wm[m]);
         rd(16'h2A12, {8'h00, wm[m] & 8'h03});
      end
      wr(16'h2A11, 8'hAF);
      rd(16'h2A11, 16'h000A);
      wr(16'h2A11, 8'h40);
      rd(16'h2A12, 16'h0000);
      rd(16'h2A11, 16'h0000);
      $display("control test done");
      for (int f = 0; f < 16; f++) begin
         @(posedge mclk);
         fault_level <= 16'h0001 << f;
         horn_active <= f[0];
         stall <= 4'(f % 3);
         frame(frm(f == 5 ? 16'h4201 : f > 13 ? 16'h8101 : 16'hFF01, f == 5 ? 8'h09 : f > 13 ? 8'h11 : 8'h81,
                   8'h01, ftype[f], {5'h0, f[0], f > 5, f <= 5}));
         @(posedge mclk);
         fault_level <= 16'h0000;
      end
      $display("fault frame test done");
      for (int s = 0; s < 8; s++) begin
         @(posedge mclk);
         stack_event <= s < 7 ? 7'h01 << s : 7'h24;
         @(posedge mclk);
         stack_event <= 7'h00;
         frame(frm(s < 7 ? scode[s] : 16'h8120, 8'h01, 8'h00, 8'h00, 8'h00));
      end
      frame(frm(16'h8210, 8'h01, 8'h00, 8'h00, 8'h00));
      $display("stack frame test done");
      report_and_stop();
   end
endmodule : tb
